// ==== verilog/pit_consts.svh ====
// offsets, field positions, reset values and timing counts of the periodic timer
`ifndef PIT_CONSTS_SVH
`define PIT_CONSTS_SVH

// register indices; byte address is four times the index
`define PIT_IDX_CTRL 8'h22
`define PIT_IDX_COUNT 8'h24
`define PIT_IDX_ARB 8'h25
`define PIT_IDX_STATUS 8'h26
`define PIT_IDX_NONE 8'hFF

// control register fields
`define PIT_CTRL_W 11
`define PIT_CTRL_LVL_HI 10
`define PIT_CTRL_LVL_LO 8
`define PIT_CTRL_VEC_HI 7
`define PIT_CTRL_VEC_LO 0
`define PIT_CTRL_RST 11'h00F

// count register fields
`define PIT_CNT_MOD_HI 7
`define PIT_CNT_MOD_LO 0
`define PIT_CNT_PRE_BIT 8
`define PIT_MOD_RST 8'h00

// arbitration and status fields
`define PIT_ARB_W 4
`define PIT_ARB_RST 4'hF
`define PIT_STAT_PEND_BIT 0
`define PIT_STAT_OVR_BIT 1
`define PIT_STAT_STRAP_BIT 2
`define PIT_STAT_CNT_LO 8
`define PIT_STAT_CNT_HI 15

// timing
`define PIT_REF_DIV 4
`define PIT_PRESCALE 512
`define PIT_STRAP_WAIT 2'h3
`define PIT_LVL_OFF 3'h0

`endif

// ==== verilog/pit_pkg.sv ====
// types shared by the periodic timer modules
package pit_pkg;

    typedef enum logic [1:0] {
        PIT_IACK_NONE,
        PIT_IACK_TIMER,
        PIT_IACK_EXT,
        PIT_IACK_SPUR
    } pit_iack_e;

    typedef struct packed {
        logic [10:0] ctrl;
        logic [7:0] modulus;
        logic prescale;
        logic [3:0] arb;
        logic pending;
        logic overrun;
        logic [2:0] sync;
        logic [1:0] strap_wait;
        logic strap_done;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic iack_ack;
        pit_iack_e iack_kind;
        logic [7:0] iack_vec;
        logic restart;
    } pit_top_s;

endpackage

// ==== verilog/pit_core_if.sv ====
// signals between the register side and the counting core
`timescale 1ns/10ps
interface pit_core_if #(
    parameter int MOD_W = 8
);
    logic [MOD_W-1:0] modulus;
    logic prescale_sel;
    logic restart;
    logic expire;
    logic [MOD_W-1:0] count_now;

    modport ctrl (
        output modulus,
        output prescale_sel,
        output restart,
        input expire,
        input count_now
    );

    modport core (
        input modulus,
        input prescale_sel,
        input restart,
        output expire,
        output count_now
    );
endinterface

// ==== verilog/pit_core.sv ====
// prescaler and modulus down counter of the periodic timer
`timescale 1ns/10ps
`include "pit_consts.svh"
module pit_core
    import pit_pkg::*;
#(
    parameter int MOD_W = 8,
    parameter int REF_DIV = `PIT_REF_DIV,
    parameter int PRESCALE = `PIT_PRESCALE
) (
    input wire logic clk,
    input wire logic rst,
    pit_core_if.core cif
);
    localparam int PRE_W = $clog2(REF_DIV * PRESCALE);
    localparam logic [PRE_W-1:0] DIV_FAST = PRE_W'(REF_DIV - 1);
    localparam logic [PRE_W-1:0] DIV_SLOW = PRE_W'(REF_DIV * PRESCALE - 1);

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [MOD_W-1:0] cnt;
        logic expire;
    } pit_core_s;

    pit_core_s st_ff;
    pit_core_s nxt_st;
    logic [PRE_W-1:0] div_top;

    generate
        if (MOD_W < 1 || REF_DIV < 2 || PRESCALE < 2)
        begin : g_bad
            $error("pit_core: unsupported parameter values");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // period = modulus * REF_DIV clocks, times PRESCALE when prescale_sel is set
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.expire = 1'b0;
        div_top = cif.prescale_sel ? DIV_SLOW : DIV_FAST;
        if (cif.modulus == '0)
        begin
            // zero modulus clears the counter and holds it at zero
            nxt_st.pre = '0;
            nxt_st.cnt = '0;
        end
        else if (cif.restart)
        begin
            nxt_st.pre = '0;
            nxt_st.cnt = cif.modulus;
        end
        else if (st_ff.pre == div_top)
        begin
            nxt_st.pre = '0;
            if (st_ff.cnt <= MOD_W'(1))
            begin
                nxt_st.expire = 1'b1;
                nxt_st.cnt = cif.modulus;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt - MOD_W'(1);
            end
        end
        else
        begin
            nxt_st.pre = st_ff.pre + PRE_W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cif.expire = st_ff.expire;
    assign cif.count_now = st_ff.cnt;
endmodule

// ==== verilog/pit_top.sv ====
// periodic interrupt timer with AHB-Lite register slave and acknowledge port
`timescale 1ns/10ps
`include "pit_consts.svh"
module pit_top
    import pit_pkg::*;
#(
    parameter int MOD_W = 8,
    parameter int REF_DIV = `PIT_REF_DIV,
    parameter int PRESCALE = `PIT_PRESCALE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic clock_mode_pin,
    input wire logic [2:0] ext_irq_level,
    input wire logic iack_req,
    input wire logic [2:0] iack_level,
    output logic [2:0] irq_level,
    output logic irq_from_timer,
    output logic iack_ack,
    output logic iack_timer,
    output logic iack_ext,
    output logic iack_spurious,
    output logic [7:0] iack_vector
);

    generate
        if (MOD_W != 8)
        begin : g_bad
            $error("pit_top: modulus field is eight bits wide");
        end
        if (REF_DIV < 2 || PRESCALE < 2)
        begin : g_bad_div
            $error("pit_top: divider and prescale must be at least two");
        end
    endgenerate

    localparam pit_top_s RST_ST = '{
        ctrl: `PIT_CTRL_RST,
        modulus: `PIT_MOD_RST,
        prescale: 1'b0,
        arb: `PIT_ARB_RST,
        pending: 1'b0,
        overrun: 1'b0,
        sync: 3'h0,
        strap_wait: 2'h0,
        strap_done: 1'b0,
        wr_pend: 1'b0,
        wr_idx: `PIT_IDX_NONE,
        rdata: 32'h0000_0000,
        iack_ack: 1'b0,
        iack_kind: PIT_IACK_NONE,
        iack_vec: 8'h00,
        restart: 1'b0
    };

    pit_top_s st_ff;
    pit_top_s nxt_st;

    pit_core_if #(.MOD_W(MOD_W)) cif ();

    logic [2:0] lvl;
    logic [2:0] timer_lvl;
    logic take;
    logic [7:0] addr_idx;
    logic ack_spur;
    logic ack_timer;
    logic ack_ext;

    ////////////////////////////////////////////////////////////////////////////////
    // counting core, always on the system unit clock

    pit_core #(
        .MOD_W(MOD_W),
        .REF_DIV(REF_DIV),
        .PRESCALE(PRESCALE)
    ) u_core (
        .clk(clk),
        .rst(rst),
        .cif(cif)
    );

    assign cif.modulus = st_ff.modulus;
    assign cif.prescale_sel = st_ff.prescale;
    assign cif.restart = st_ff.restart;

    ////////////////////////////////////////////////////////////////////////////////
    // register read view

    function automatic logic [31:0] read_reg(
        input pit_top_s s,
        input logic [7:0] idx,
        input logic [7:0] cnt
    );
        logic [31:0] r;
        r = 32'h0000_0000;
        case (idx)
            `PIT_IDX_CTRL:
            begin
                r[`PIT_CTRL_W-1:0] = s.ctrl;
            end
            `PIT_IDX_COUNT:
            begin
                r[`PIT_CNT_MOD_HI:`PIT_CNT_MOD_LO] = s.modulus;
                r[`PIT_CNT_PRE_BIT] = s.prescale;
            end
            `PIT_IDX_ARB:
            begin
                r[`PIT_ARB_W-1:0] = s.arb;
            end
            `PIT_IDX_STATUS:
            begin
                r[`PIT_STAT_PEND_BIT] = s.pending;
                r[`PIT_STAT_OVR_BIT] = s.overrun;
                r[`PIT_STAT_STRAP_BIT] = s.strap_done;
                r[`PIT_STAT_CNT_HI:`PIT_STAT_CNT_LO] = cnt;
            end
            default:
            begin
                r = 32'h0000_0000;
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // request level and its arbitration against the external request

    assign lvl = st_ff.ctrl[`PIT_CTRL_LVL_HI:`PIT_CTRL_LVL_LO];
    assign timer_lvl = st_ff.pending ? lvl : `PIT_LVL_OFF;

    always_comb
    begin
        // a tie goes to the timer
        if (timer_lvl != `PIT_LVL_OFF && timer_lvl >= ext_irq_level)
        begin
            irq_level = timer_lvl;
            irq_from_timer = 1'b1;
        end
        else
        begin
            irq_level = ext_irq_level;
            irq_from_timer = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // acknowledge decision: arbitration field first, then timer, then external

    always_comb
    begin
        ack_spur = 1'b0;
        ack_timer = 1'b0;
        ack_ext = 1'b0;
        if (st_ff.arb == 4'h0)
        begin
            ack_spur = 1'b1;
        end
        else if (timer_lvl != `PIT_LVL_OFF && iack_level == timer_lvl)
        begin
            ack_timer = 1'b1;
        end
        else if (ext_irq_level != `PIT_LVL_OFF && iack_level == ext_irq_level)
        begin
            ack_ext = 1'b1;
        end
        else
        begin
            ack_spur = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus address decode

    assign take = hsel && hready && htrans[1];

    always_comb
    begin
        if (haddr[1:0] == 2'b00 && haddr[31:10] == 22'h00_0000)
        begin
            addr_idx = haddr[9:2];
        end
        else
        begin
            addr_idx = `PIT_IDX_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.restart = 1'b0;
        nxt_st.iack_ack = 1'b0;
        nxt_st.iack_kind = PIT_IACK_NONE;

        // clock-mode pin through three flops
        nxt_st.sync = {st_ff.sync[1:0], clock_mode_pin};

        // catch the strap once the synchroniser has filled after release
        if (!st_ff.strap_done)
        begin
            if (st_ff.strap_wait != `PIT_STRAP_WAIT)
            begin
                nxt_st.strap_wait = st_ff.strap_wait + 2'h1;
            end
            else if (st_ff.sync[1] == st_ff.sync[2])
            begin
                nxt_st.prescale = ~st_ff.sync[2];
                nxt_st.strap_done = 1'b1;
                nxt_st.restart = 1'b1;
            end
        end

        // address phase
        nxt_st.wr_pend = take && hwrite;
        if (take)
        begin
            nxt_st.wr_idx = addr_idx;
        end
        if (take && !hwrite)
        begin
            nxt_st.rdata = read_reg(st_ff, addr_idx, cif.count_now);
        end

        // data phase of a write
        if (st_ff.wr_pend)
        begin
            case (st_ff.wr_idx)
                `PIT_IDX_CTRL:
                begin
                    nxt_st.ctrl = hwdata[`PIT_CTRL_W-1:0];
                end
                `PIT_IDX_COUNT:
                begin
                    nxt_st.modulus = hwdata[`PIT_CNT_MOD_HI:`PIT_CNT_MOD_LO];
                    nxt_st.prescale = hwdata[`PIT_CNT_PRE_BIT];
                    nxt_st.strap_done = 1'b1;
                    nxt_st.restart = 1'b1;
                end
                `PIT_IDX_ARB:
                begin
                    nxt_st.arb = hwdata[`PIT_ARB_W-1:0];
                end
                `PIT_IDX_STATUS:
                begin
                    if (hwdata[`PIT_STAT_OVR_BIT])
                    begin
                        nxt_st.overrun = 1'b0;
                    end
                end
                default:
                begin
                    nxt_st.wr_idx = st_ff.wr_idx;
                end
            endcase
        end

        // interrupt acknowledge cycle
        if (iack_req)
        begin
            nxt_st.iack_ack = 1'b1;
            if (ack_timer)
            begin
                nxt_st.iack_kind = PIT_IACK_TIMER;
                nxt_st.iack_vec = st_ff.ctrl[`PIT_CTRL_VEC_HI:`PIT_CTRL_VEC_LO];
                nxt_st.pending = 1'b0;
            end
            else if (ack_ext)
            begin
                nxt_st.iack_kind = PIT_IACK_EXT;
            end
            else
            begin
                nxt_st.iack_kind = PIT_IACK_SPUR;
            end
        end

        // expiry sets pending after any clear above, so the set wins
        if (cif.expire && lvl != `PIT_LVL_OFF)
        begin
            if (st_ff.pending && nxt_st.pending)
            begin
                nxt_st.overrun = 1'b1;
            end
            nxt_st.pending = 1'b1;
        end

        // a request level of zero drops any request still waiting
        if (nxt_st.ctrl[`PIT_CTRL_LVL_HI:`PIT_CTRL_LVL_LO] == `PIT_LVL_OFF)
        begin
            nxt_st.pending = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= RST_ST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;
    assign iack_ack = st_ff.iack_ack;
    assign iack_timer = st_ff.iack_kind == PIT_IACK_TIMER;
    assign iack_ext = st_ff.iack_kind == PIT_IACK_EXT;
    assign iack_spurious = st_ff.iack_kind == PIT_IACK_SPUR;
    assign iack_vector = st_ff.iack_vec;

endmodule

// ==== bench/pit_props.sv ====
// concurrent checks on the periodic timer ports
`timescale 1ns/10ps
module pit_props
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] ext_irq_level,
    input wire logic iack_req,
    input wire logic [2:0] iack_level,
    input wire logic [2:0] irq_level,
    input wire logic irq_from_timer,
    input wire logic iack_ack,
    input wire logic iack_timer,
    input wire logic iack_ext,
    input wire logic iack_spurious,
    input wire logic [7:0] iack_vector
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack; iack_req |=> iack_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_one; !iack_req |=> !iack_ack; endproperty
    a_one: assert property (p_one) else $error("stray ack");
    property p_kind; iack_ack |-> $onehot({iack_timer, iack_ext, iack_spurious}); endproperty
    a_kind: assert property (p_kind) else $error("answer kind");
    property p_flag; !iack_ack |-> !(iack_timer || iack_ext || iack_spurious); endproperty
    a_flag: assert property (p_flag) else $error("kind without ack");
    property p_tie; iack_req && irq_from_timer && iack_level == irq_level |=> !iack_ext; endproperty
    a_tie: assert property (p_tie) else $error("external won tie");
    property p_ext; iack_ext |-> $past(ext_irq_level) == $past(iack_level); endproperty
    a_ext: assert property (p_ext) else $error("external level");
    property p_vec; !iack_timer |-> $stable(iack_vector); endproperty
    a_vec: assert property (p_vec) else $error("vector moved");
    property p_src; !irq_from_timer |-> irq_level == ext_irq_level; endproperty
    a_src: assert property (p_src) else $error("request source");
    property p_lvl; irq_from_timer |-> irq_level != 3'h0 && irq_level >= ext_irq_level; endproperty
    a_lvl: assert property (p_lvl) else $error("timer level");
endmodule

bind pit_top pit_props u_props (.clk, .rst, .ext_irq_level, .iack_req, .iack_level,
    .irq_level, .irq_from_timer, .iack_ack, .iack_timer, .iack_ext, .iack_spurious,
    .iack_vector);

// ==== bench/pit_cpu_model.sv ====
// processor side: runs acknowledge cycles for pending requests
`timescale 1ns/10ps
module pit_cpu_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] irq_level,
    input wire logic iack_ack,
    input wire logic [2:0] flags,
    input wire logic on,
    input wire logic [3:0] gap,
    output logic iack_req,
    output logic [2:0] iack_level,
    output logic [2:0] kind,
    output logic [15:0] n
);
    logic [2:0] lvl;
    logic busy;
    logic [3:0] w;
    // level lines float when idle: show the inverse of the last level
    assign iack_level = iack_req ? lvl : ~lvl;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            iack_req <= 1'b0;
            lvl <= 3'h0;
            busy <= 1'b0;
            w <= 4'h0;
            kind <= 3'h0;
            n <= 16'h0;
        end
        else
        begin
            iack_req <= 1'b0;
            if (iack_ack)
            begin
                busy <= 1'b0;
                kind <= flags;
                n <= n + 16'h1;
            end
            else if (on && !busy && irq_level != 3'h0)
            begin
                w <= w + 4'h1;
                if (w >= gap)
                begin
                    iack_req <= 1'b1;
                    lvl <= irq_level;
                    busy <= 1'b1;
                    w <= 4'h0;
                end
            end
        end
    end
endmodule

// ==== bench/periodic_interrupt_timer_test.sv ====
// self-checking bench of the periodic interrupt timer
`timescale 1ns/10ps
`include "pit_consts.svh"
module periodic_interrupt_timer_test;
    localparam int PRE = 4;
    localparam logic [31:0] A_CTL = {22'h0, `PIT_IDX_CTRL, 2'h0};
    localparam logic [31:0] A_CNT = {22'h0, `PIT_IDX_COUNT, 2'h0};
    localparam logic [31:0] A_ARB = {22'h0, `PIT_IDX_ARB, 2'h0};
    localparam logic [31:0] A_STA = {22'h0, `PIT_IDX_STATUS, 2'h0};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic clock_mode_pin = 1'b0;
    logic [2:0] ext_irq_level = 3'h0;
    logic on = 1'b1;
    logic [3:0] gap = 4'h0;
    logic hready, hreadyout, hresp, irq_from_timer, iack_ack, iack_timer, iack_ext;
    logic iack_spurious, iack_req;
    logic [31:0] hrdata;
    logic [2:0] iack_level, irq_level, kind;
    logic [7:0] iack_vector;
    logic [15:0] n;
    int cyc = 0, num_errors = 0, num_checks = 0;

    pit_top #(.PRESCALE(PRE)) dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .clock_mode_pin, .ext_irq_level,
        .iack_req, .iack_level, .irq_level, .irq_from_timer, .iack_ack, .iack_timer,
        .iack_ext, .iack_spurious, .iack_vector);
    pit_cpu_model cpu (.clk, .rst, .irq_level, .iack_ack,
        .flags({iack_timer, iack_ext, iack_spurious}), .on, .gap, .iack_req, .iack_level,
        .kind, .n);

    assign hready = hreadyout;
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wt(input logic [2:0] l);
        int i;
        for (i = 0; i < 9000 && irq_level !== l; i++)
            @(negedge clk);
        chk("irq level", {29'h0, irq_level}, {29'h0, l});
    endtask
    task automatic per(input logic [2:0] l, input int exp);
        int t0;
        wt(3'h0);
        wt(l);
        t0 = cyc;
        wt(3'h0);
        wt(l);
        chk("period", 32'(cyc - t0), 32'(exp));
    endtask
    task automatic wn(input logic [2:0] k);
        logic [15:0] n0;
        int i;
        @(negedge clk);
        n0 = n;
        for (i = 0; i < 2000 && n === n0; i++)
            @(negedge clk);
        chk("ack kind", {29'h0, kind}, {29'h0, k});
    endtask
    task automatic quiet(input string nm);
        logic [2:0] s;
        s = 3'h0;
        repeat (40)
        begin
            @(negedge clk);
            s = s | irq_level;
        end
        chk(nm, {29'h0, s}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] r;
        repeat (6) @(posedge clk);
        bus(1'b0, A_CTL, 32'h0, r);
        chk("ctl reset", r, {21'h0, `PIT_CTRL_RST});
        bus(1'b0, A_CNT, 32'h0, r);
        chk("cnt reset", r, 32'h100);
        bus(1'b0, A_ARB, 32'h0, r);
        chk("arb reset", r, {28'h0, `PIT_ARB_RST});
        bus(1'b0, A_STA, 32'h0, r);
        chk("strap flag", r, 32'h4);
        bus(1'b1, A_CTL, 32'hFFFF_FFFF, r);
        bus(1'b0, A_CTL, 32'h0, r);
        chk("ctl bits", r, 32'h7FF);
        bus(1'b1, A_CNT, 32'hFFFF_FFFF, r);
        bus(1'b0, A_CNT, 32'h0, r);
        chk("cnt bits", r, 32'h1FF);
        bus(1'b0, 32'h3FC, 32'h0, r);
        chk("unmapped", r, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_time();
        logic [31:0] r;
        bus(1'b1, A_CTL, 32'h35A, r);
        bus(1'b1, A_CNT, 32'h3, r);
        per(3'h3, 3 * `PIT_REF_DIV);
        chk("vector", {24'h0, iack_vector}, 32'h5A);
        chk("kind", {29'h0, kind}, 32'h4);
        gap <= 4'h9;
        bus(1'b1, A_CNT, 32'h103, r);
        per(3'h3, 3 * `PIT_REF_DIV * PRE);
        gap <= 4'h0;
        $display("test timing done");
    endtask
    task automatic t_off();
        logic [31:0] r;
        int t0;
        bus(1'b1, A_CTL, 32'h05A, r);
        bus(1'b1, A_CNT, 32'h2, r);
        quiet("level off");
        bus(1'b1, A_CTL, 32'h25A, r);
        t0 = cyc;
        wt(3'h2);
        chk("running", 32'(cyc - t0 < 12), 32'h1);
        bus(1'b1, A_CTL, 32'h05A, r);
        bus(1'b1, A_CNT, 32'h0, r);
        bus(1'b1, A_CTL, 32'h35A, r);
        quiet("zero modulus");
        $display("test off done");
    endtask
    task automatic t_tie();
        logic [31:0] r;
        int i;
        on <= 1'b0;
        bus(1'b1, A_CNT, 32'hFF, r);
        ext_irq_level <= 3'h3;
        for (i = 0; i < 1100 && irq_from_timer !== 1'b1; i++)
            @(negedge clk);
        on <= 1'b1;
        wn(3'h4);
        wn(3'h2);
        on <= 1'b0;
        bus(1'b1, A_ARB, 32'h0, r);
        on <= 1'b1;
        wn(3'h1);
        bus(1'b1, A_ARB, 32'hF, r);
        ext_irq_level <= 3'h0;
        bus(1'b1, A_CNT, 32'h0, r);
        $display("test tie done");
    endtask
    task automatic t_strap();
        logic [31:0] r;
        @(posedge clk);
        rst <= 1'b1;
        clock_mode_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        bus(1'b0, A_CNT, 32'h0, r);
        chk("cnt strap high", r, 32'h0);
        bus(1'b0, A_STA, 32'h0, r);
        chk("strap flag 2", r, 32'h4);
        bus(1'b0, A_CTL, 32'h0, r);
        chk("ctl reset 2", r, {21'h0, `PIT_CTRL_RST});
        $display("test strap done");
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #2000000;
        num_errors++;
        stop_test();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_time();
        t_off();
        t_tie();
        t_strap();
        stop_test();
    end
endmodule
